// [logic/lac_regs.sv]
// Control and status registers of the 32-element logic array, AHB-Lite slave.
// Assumes the element logic and clock muxes sit outside; element outputs
// may run on other clocks and are synchronised here.
`timescale 1ns/1ps

module lac_regs
    import lac_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [LAC_ELEMS-1:0] ELEM_OUT,
    output logic [LAC_HALF_ELEMS-1:0] SW_DIN,
    output lac_clk_src_type GROUP0_CLOCK_SEL,
    output lac_clk_src_type GROUP1_CLOCK_SEL,
    output lac_clk_src_type GROUP2_CLOCK_SEL,
    output lac_clk_src_type GROUP3_CLOCK_SEL,
    output logic [LAC_IRQ_REQS-1:0] IRQ_REQ,
    output logic CONVST_TRIG,
    output logic WRITE_LOCKED,
    output logic INT
);

    // Bus slave state
    lac_bus_state_type bus_state_r;
    lac_bus_state_type bus_state_nxt;
    lac_ahb_req_type req_r;
    lac_ahb_req_type req_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic hreadyout_r;
    logic hreadyout_nxt;
    logic hresp_r;
    logic hresp_nxt;
    logic accept;
    logic wr_commit;
    logic [15:0] wdata;
    logic [15:0] rd_val;
    logic wr_clk_sel;
    logic wr_route_lo;
    logic wr_route_hi;
    logic wr_conv;
    logic wr_swin;
    logic wr_lock;
    logic wr_evt_status;
    logic wr_evt_mask;

    // Configuration state
    logic [15:0] clk_sel_r;
    logic [15:0] clk_sel_nxt;
    lac_route_type route_r [LAC_IRQ_REQS];
    lac_route_type route_nxt [LAC_IRQ_REQS];
    lac_conv_type conv_r;
    lac_conv_type conv_nxt;
    logic [15:0] swin_r;
    logic [15:0] swin_nxt;
    logic lock_r;
    logic lock_nxt;
    logic cfg_wr_ok;

    // Request and event state
    logic [LAC_ELEMS-1:0] elem_sync;
    logic [LAC_IRQ_REQS-1:0] req_sel;
    logic conv_sel;
    logic [LAC_IRQ_REQS-1:0] irq_r;
    logic [LAC_IRQ_REQS-1:0] irq_nxt;
    logic convst_r;
    logic convst_nxt;
    logic [LAC_EVT_W-1:0] evt_status_r;
    logic [LAC_EVT_W-1:0] evt_status_nxt;
    logic [LAC_EVT_W-1:0] evt_mask_r;
    logic [LAC_EVT_W-1:0] evt_mask_nxt;
    logic [LAC_EVT_W-1:0] evt_set;
    logic [LAC_EVT_W-1:0] evt_clr;
    logic int_r;
    logic int_nxt;

    function automatic lac_route_type to_route(input logic [7:0] b);
        lac_route_type r;
        r.unused = 3'h0;
        r.enable = b[LAC_ROUTE_EN_POS];
        r.source = b[LAC_ROUTE_SRC_W-1:0];
        return r;
    endfunction

    // Element outputs cross into the system clock domain
    lac_sync #(
        .WIDTH(LAC_ELEMS)
    ) u_elem_sync (
        .clk(CLK_SYS),
        .nrst(NRST),
        .ce(CE),
        .d(ELEM_OUT),
        .q(elem_sync)
    );

    // Interrupt request selectors
    genvar gi;
    generate
        for (gi = 0; gi < LAC_IRQ_REQS; gi++) begin : g_req
            logic [LAC_HALF_ELEMS-1:0] half;
            if (gi < 2) begin : g_low
                assign half = elem_sync[LAC_HALF_ELEMS-1:0];
            end else begin : g_high
                assign half = elem_sync[LAC_ELEMS-1:LAC_HALF_ELEMS];
            end
            lac_route_sel #(
                .SEL_W(LAC_ROUTE_SRC_W)
            ) u_sel (
                .src_vec(half),
                .sel(route_r[gi].source),
                .enable(route_r[gi].enable),
                .out(req_sel[gi])
            );
        end
    endgenerate

    // Conversion trigger selector
    lac_route_sel #(
        .SEL_W(LAC_CONV_SRC_W)
    ) u_conv_sel (
        .src_vec(elem_sync),
        .sel(conv_r.source),
        .enable(conv_r.enable),
        .out(conv_sel)
    );

    // Register read mux; reserved bits are zero
    always_comb begin
        if (req_r.addr == LAC_ADDR_CLK_SEL) begin
            rd_val = clk_sel_r;
        end else if (req_r.addr == LAC_ADDR_ROUTE_LO) begin
            rd_val = {route_r[1], route_r[0]};
        end else if (req_r.addr == LAC_ADDR_ROUTE_HI) begin
            rd_val = {route_r[3], route_r[2]};
        end else if (req_r.addr == LAC_ADDR_CONV) begin
            rd_val = {10'h000, conv_r};
        end else if (req_r.addr == LAC_ADDR_SWIN) begin
            rd_val = swin_r;
        end else if (req_r.addr == LAC_ADDR_OUT_LO) begin
            rd_val = elem_sync[LAC_HALF_ELEMS-1:0];
        end else if (req_r.addr == LAC_ADDR_OUT_HI) begin
            rd_val = elem_sync[LAC_ELEMS-1:LAC_HALF_ELEMS];
        end else if (req_r.addr == LAC_ADDR_LOCK) begin
            rd_val = {15'h0000, lock_r};
        end else if (req_r.addr == LAC_ADDR_EVT_STATUS) begin
            rd_val = {11'h000, evt_status_r};
        end else if (req_r.addr == LAC_ADDR_EVT_MASK) begin
            rd_val = {11'h000, evt_mask_r};
        end else begin
            rd_val = LAC_RST_REG;
        end
    end

    // Bus handshake: writes have no wait, reads one wait cycle
    assign accept = HSEL && HTRANS[1] && HREADY;
    assign wr_commit = (bus_state_r == LAC_BUS_WRITE) && HREADY;
    assign wdata = HWDATA[15:0];

    // Write strobes decoded once; read-only and unmapped addresses get none
    always_comb begin
        wr_clk_sel = 1'b0;
        wr_route_lo = 1'b0;
        wr_route_hi = 1'b0;
        wr_conv = 1'b0;
        wr_swin = 1'b0;
        wr_lock = 1'b0;
        wr_evt_status = 1'b0;
        wr_evt_mask = 1'b0;
        if (req_r.addr == LAC_ADDR_CLK_SEL) begin
            wr_clk_sel = wr_commit;
        end else if (req_r.addr == LAC_ADDR_ROUTE_LO) begin
            wr_route_lo = wr_commit;
        end else if (req_r.addr == LAC_ADDR_ROUTE_HI) begin
            wr_route_hi = wr_commit;
        end else if (req_r.addr == LAC_ADDR_CONV) begin
            wr_conv = wr_commit;
        end else if (req_r.addr == LAC_ADDR_SWIN) begin
            wr_swin = wr_commit;
        end else if (req_r.addr == LAC_ADDR_LOCK) begin
            wr_lock = wr_commit;
        end else if (req_r.addr == LAC_ADDR_EVT_STATUS) begin
            wr_evt_status = wr_commit;
        end else if (req_r.addr == LAC_ADDR_EVT_MASK) begin
            wr_evt_mask = wr_commit;
        end
    end

    always_comb begin
        bus_state_nxt = bus_state_r;
        req_nxt = req_r;
        hrdata_nxt = hrdata_r;
        hreadyout_nxt = 1'b1;
        hresp_nxt = 1'b0;
        case (bus_state_r)
            LAC_BUS_READ: begin
                hrdata_nxt = {16'h0000, rd_val};
                bus_state_nxt = LAC_BUS_IDLE;
            end
            default: begin
                if (HREADY) begin
                    if (accept) begin
                        req_nxt.write = HWRITE;
                        req_nxt.addr = HADDR;
                        hreadyout_nxt = HWRITE;
                        bus_state_nxt = HWRITE ? LAC_BUS_WRITE : LAC_BUS_READ;
                    end else begin
                        bus_state_nxt = LAC_BUS_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            bus_state_r <= LAC_BUS_IDLE;
            req_r <= '0;
            hrdata_r <= LAC_RST_WORD;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else if (CE) begin
            bus_state_r <= bus_state_nxt;
            req_r <= req_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= hreadyout_nxt;
            hresp_r <= hresp_nxt;
        end
    end

    // Configuration writes, blocked once locked
    assign cfg_wr_ok = wr_commit && !lock_r;

    always_comb begin
        clk_sel_nxt = clk_sel_r;
        route_nxt = route_r;
        conv_nxt = conv_r;
        swin_nxt = swin_r;
        lock_nxt = lock_r;
        if (cfg_wr_ok) begin
            if (wr_clk_sel) begin
                clk_sel_nxt = wdata & LAC_CLK_SEL_MASK;
            end else if (wr_route_lo) begin
                route_nxt[0] = to_route(wdata[LAC_ROUTE_LO_POS +: 8]);
                route_nxt[1] = to_route(wdata[LAC_ROUTE_HI_POS +: 8]);
            end else if (wr_route_hi) begin
                route_nxt[2] = to_route(wdata[LAC_ROUTE_LO_POS +: 8]);
                route_nxt[3] = to_route(wdata[LAC_ROUTE_HI_POS +: 8]);
            end else if (wr_conv) begin
                conv_nxt.enable = wdata[LAC_CONV_EN_POS];
                conv_nxt.source = wdata[LAC_CONV_SRC_W-1:0];
            end else if (wr_swin) begin
                swin_nxt = wdata;
            end
        end
        // Only a one sets the lock; nothing clears it short of reset
        if (wr_lock && wdata[LAC_LOCK_POS]) begin
            lock_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            clk_sel_r <= LAC_RST_REG;
            for (int i = 0; i < LAC_IRQ_REQS; i++) begin
                route_r[i] <= '0;
            end
            conv_r <= '0;
            swin_r <= LAC_RST_REG;
            lock_r <= 1'b0;
        end else if (CE) begin
            clk_sel_r <= clk_sel_nxt;
            route_r <= route_nxt;
            conv_r <= conv_nxt;
            swin_r <= swin_nxt;
            lock_r <= lock_nxt;
        end
    end

    // Requests, trigger and sticky events; a new event beats its clear
    always_comb begin
        irq_nxt = req_sel;
        convst_nxt = conv_sel;
        evt_set = {convst_nxt & ~convst_r, irq_nxt & ~irq_r};
        evt_clr = '0;
        evt_mask_nxt = evt_mask_r;
        if (wr_evt_status) begin
            evt_clr = wdata[LAC_EVT_W-1:0];
        end
        if (wr_evt_mask) begin
            evt_mask_nxt = wdata[LAC_EVT_W-1:0];
        end
        evt_status_nxt = (evt_status_r & ~evt_clr) | evt_set;
        int_nxt = |(evt_status_nxt & evt_mask_nxt);
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_r <= '0;
            convst_r <= 1'b0;
            evt_status_r <= '0;
            evt_mask_r <= '0;
            int_r <= 1'b0;
        end else if (CE) begin
            irq_r <= irq_nxt;
            convst_r <= convst_nxt;
            evt_status_r <= evt_status_nxt;
            evt_mask_r <= evt_mask_nxt;
            int_r <= int_nxt;
        end
    end

    // Outputs straight from registers
    assign HRDATA = hrdata_r;
    assign HREADYOUT = hreadyout_r;
    assign HRESP = hresp_r;
    assign SW_DIN = swin_r;
    assign GROUP0_CLOCK_SEL = lac_clk_src_type'(clk_sel_r[0 +: LAC_GRP_SEL_W]);
    assign GROUP1_CLOCK_SEL =
        lac_clk_src_type'(clk_sel_r[LAC_GRP_SEL_STRIDE +: LAC_GRP_SEL_W]);
    assign GROUP2_CLOCK_SEL =
        lac_clk_src_type'(clk_sel_r[2 * LAC_GRP_SEL_STRIDE +: LAC_GRP_SEL_W]);
    assign GROUP3_CLOCK_SEL =
        lac_clk_src_type'(clk_sel_r[3 * LAC_GRP_SEL_STRIDE +: LAC_GRP_SEL_W]);
    assign IRQ_REQ = irq_r;
    assign CONVST_TRIG = convst_r;
    assign WRITE_LOCKED = lock_r;
    assign INT = int_r;

endmodule

// [logic/lac_pkg.sv]
// Shared constants and types for the logic array control register bank.
// Assumes a 32-bit AHB-Lite bus where each register takes one aligned word.
package lac_pkg;

    // Register byte addresses
    localparam logic [31:0] LAC_ADDR_CLK_SEL = 32'h4000_5880;
    localparam logic [31:0] LAC_ADDR_ROUTE_LO = 32'h4000_5884;
    localparam logic [31:0] LAC_ADDR_ROUTE_HI = 32'h4000_5888;
    localparam logic [31:0] LAC_ADDR_CONV = 32'h4000_588C;
    localparam logic [31:0] LAC_ADDR_SWIN = 32'h4000_5890;
    localparam logic [31:0] LAC_ADDR_OUT_LO = 32'h4000_5898;
    localparam logic [31:0] LAC_ADDR_OUT_HI = 32'h4000_589C;
    localparam logic [31:0] LAC_ADDR_LOCK = 32'h4000_58A0;
    localparam logic [31:0] LAC_ADDR_EVT_STATUS = 32'h4000_58A4;
    localparam logic [31:0] LAC_ADDR_EVT_MASK = 32'h4000_58A8;

    // Values after reset
    localparam logic [15:0] LAC_RST_REG = 16'h0000;
    localparam logic [31:0] LAC_RST_WORD = 32'h0000_0000;

    // Field layout
    localparam int LAC_ELEMS = 32;
    localparam int LAC_HALF_ELEMS = 16;
    localparam int LAC_GROUPS = 4;
    localparam int LAC_GRP_SEL_W = 3;
    localparam int LAC_GRP_SEL_STRIDE = 4;
    localparam logic [15:0] LAC_CLK_SEL_MASK = 16'h7777;
    localparam int LAC_IRQ_REQS = 4;
    localparam int LAC_ROUTE_SRC_W = 4;
    localparam int LAC_ROUTE_LO_POS = 0;
    localparam int LAC_ROUTE_HI_POS = 8;
    localparam int LAC_ROUTE_EN_POS = 4;
    localparam int LAC_CONV_SRC_W = 5;
    localparam int LAC_CONV_EN_POS = 5;
    localparam int LAC_LOCK_POS = 0;

    // Event status and mask bits
    localparam int LAC_EVT_W = 5;
    localparam int LAC_EVT_CONV_POS = 4;

    // Data phase of a read takes this many wait cycles
    localparam int LAC_READ_WAIT_CYCLES = 1;

    // Block clock source codes
    typedef enum logic [2:0] {
        LAC_CLK_PIN_A = 3'h0,
        LAC_CLK_PIN_B = 3'h1,
        LAC_CLK_PIN_C = 3'h2,
        LAC_CLK_BUS = 3'h3,
        LAC_CLK_FAST_OSC = 3'h4,
        LAC_CLK_TIMER_ZERO = 3'h5,
        LAC_CLK_TIMER_TWO = 3'h6,
        LAC_CLK_SLOW_OSC = 3'h7
    } lac_clk_src_type;

    // One interrupt route field, one byte of a route register
    typedef struct packed {
        logic [2:0] unused;
        logic enable;
        logic [3:0] source;
    } lac_route_type;

    typedef struct packed {
        logic enable;
        logic [4:0] source;
    } lac_conv_type;

    typedef struct packed {
        logic write;
        logic [31:0] addr;
    } lac_ahb_req_type;

    typedef enum logic [1:0] {
        LAC_BUS_IDLE = 2'h0,
        LAC_BUS_WRITE = 2'h1,
        LAC_BUS_READ = 2'h3
    } lac_bus_state_type;

endpackage

// [logic/lac_sync.sv]
// Two-stage synchroniser for a vector of levels.
// Assumes each bit is a slow level; bits are not coherent with one another.
`timescale 1ns/1ps
module lac_sync
    import lac_pkg::*;
#(
    parameter int WIDTH = LAC_ELEMS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q_r <= '0;
        end else if (ce) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule

// [logic/lac_route_sel.sv]
// Picks one element output by number and gates it with an enable.
// Assumes the source vector is already in the system clock domain.
`timescale 1ns/1ps
module lac_route_sel
    import lac_pkg::*;
#(
    parameter int SEL_W = LAC_ROUTE_SRC_W
) (
    input wire logic [(1 << SEL_W)-1:0] src_vec,
    input wire logic [SEL_W-1:0] sel,
    input wire logic enable,
    output logic out
);

    always_comb begin
        out = enable & src_vec[sel];
    end

endmodule

// [test/lac_regs_props.sv]
// Checker for the logic array control register bank.
// Bound to lac_regs; watches only its ports, one clock domain.
`timescale 1ns/1ps
module lac_regs_props
    import lac_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [LAC_HALF_ELEMS-1:0] SW_DIN,
    input wire lac_clk_src_type GROUP0_CLOCK_SEL,
    input wire lac_clk_src_type GROUP3_CLOCK_SEL,
    input wire logic CONVST_TRIG,
    input wire logic WRITE_LOCKED
);
    logic take, wr_r, wr_nxt, conv_r, conv_nxt;
    logic [31:0] addr_r, addr_nxt;
    assign take = HSEL && HTRANS[1] && HREADY && CE;
    // Shadow of the write data phase and of the conversion enable
    always_comb begin
        wr_nxt = CE ? (take && HWRITE) : wr_r;
        addr_nxt = (take && HWRITE) ? HADDR : addr_r;
        conv_nxt = conv_r;
        if (wr_r && CE && addr_r == LAC_ADDR_CONV && !WRITE_LOCKED) begin
            conv_nxt = HWDATA[LAC_CONV_EN_POS];
        end
    end
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            wr_r <= 1'b0;
            addr_r <= 32'h0000_0000;
            conv_r <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            conv_r <= conv_nxt;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    property p_resp_okay;
        HRESP == 1'b0;
    endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("error response");
    property p_read_wait;
        take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
    property p_rdata_upper;
        HREADYOUT |-> HRDATA[31:16] == 16'h0000;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper data set");
    property p_lock_sticky;
        WRITE_LOCKED |=> WRITE_LOCKED;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");
    property p_lock_set;
        wr_r && CE && addr_r == LAC_ADDR_LOCK && HWDATA[0] |=> WRITE_LOCKED;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set");
    property p_clk_update;
        wr_r && CE && addr_r == LAC_ADDR_CLK_SEL && !WRITE_LOCKED |=>
            GROUP0_CLOCK_SEL == $past(HWDATA[2:0]) && GROUP3_CLOCK_SEL == $past(HWDATA[14:12]);
    endproperty
    a_clk_update: assert property (p_clk_update) else $error("clock select wrong");
    property p_swin_update;
        wr_r && CE && addr_r == LAC_ADDR_SWIN && !WRITE_LOCKED |=> SW_DIN == $past(HWDATA[15:0]);
    endproperty
    a_swin_update: assert property (p_swin_update) else $error("input bits wrong");
    property p_locked_hold;
        wr_r && CE && WRITE_LOCKED |=> $stable(SW_DIN) && $stable(GROUP0_CLOCK_SEL);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("locked write seen");
    property p_conv_off;
        !conv_r && !$past(conv_r) |-> !CONVST_TRIG;
    endproperty
    a_conv_off: assert property (p_conv_off) else $error("trigger while off");
endmodule
bind lac_regs lac_regs_props u_props (.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SW_DIN(SW_DIN),
    .GROUP0_CLOCK_SEL(GROUP0_CLOCK_SEL), .GROUP3_CLOCK_SEL(GROUP3_CLOCK_SEL),
    .CONVST_TRIG(CONVST_TRIG), .WRITE_LOCKED(WRITE_LOCKED));

// [test/test_logic_array_control_regs.sv]
// Self-checking bench for the logic array control register bank.
// Bench is the only AHB-Lite master; HREADY is tied to HREADYOUT.
`timescale 1ns/1ps
module test_logic_array_control_regs
    import lac_pkg::*;
;
    logic clk_sys, nrst, ce, hsel, hwrite, hready, hreadyout, hresp;
    logic convst_trig, write_locked, int_out;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, elem_out, rd;
    logic [15:0] sw_din;
    logic [3:0] irq_req;
    lac_clk_src_type g0, g1, g2, g3;
    int fail_count, total_checks;
    assign hready = hreadyout;
    lac_regs dut (.CLK_SYS(clk_sys), .NRST(nrst), .CE(ce), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .ELEM_OUT(elem_out),
        .SW_DIN(sw_din), .GROUP0_CLOCK_SEL(g0), .GROUP1_CLOCK_SEL(g1), .GROUP2_CLOCK_SEL(g2),
        .GROUP3_CLOCK_SEL(g3), .IRQ_REQ(irq_req), .CONVST_TRIG(convst_trig),
        .WRITE_LOCKED(write_locked), .INT(int_out));
    task automatic close_out;
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
    endtask
    task automatic t_reset;
        logic [31:0] adr [11] = '{LAC_ADDR_CLK_SEL, LAC_ADDR_ROUTE_LO, LAC_ADDR_ROUTE_HI,
            LAC_ADDR_CONV, LAC_ADDR_SWIN, LAC_ADDR_OUT_LO, LAC_ADDR_OUT_HI, LAC_ADDR_LOCK,
            LAC_ADDR_EVT_STATUS, LAC_ADDR_EVT_MASK, 32'h4000_58B0};
        foreach (adr[i]) rdc("reset read", adr[i], LAC_RST_WORD);
        chk("reset outs", 32'h0, {9'h0, sw_din, irq_req, convst_trig, write_locked, int_out});
        chk("reset groups", 32'h0, {20'h0, g3, g2, g1, g0});
    endtask
    task automatic t_clk;
        for (int c = 0; c < 8; c++) begin
            wr(LAC_ADDR_CLK_SEL, {16'h0, {4{1'b1, c[2:0]}}});
            tick(1);
            chk("group codes", {20'h0, {4{c[2:0]}}}, {20'h0, g3, g2, g1, g0});
            rdc("clock read", LAC_ADDR_CLK_SEL, {16'h0, {4{1'b0, c[2:0]}}});
        end
        wr(LAC_ADDR_CLK_SEL, 32'h0000_4321);
        tick(1);
        chk("group fields", {20'h0, 3'h4, 3'h3, 3'h2, 3'h1}, {20'h0, g3, g2, g1, g0});
    endtask
    task automatic req(input logic [31:0] e, input logic [3:0] exp);
        elem_out <= e;
        tick(4);
        chk("requests", {28'h0, exp}, {28'h0, irq_req});
    endtask
    task automatic t_route;
        wr(LAC_ADDR_ROUTE_LO, 32'h0000_1B15);
        wr(LAC_ADDR_ROUTE_HI, 32'h0000_1B13);
        req(32'h0000_0020, 4'b0001);
        req(32'h0000_0800, 4'b0010);
        req(32'h0808_0000, 4'b1100);
        req(32'h0000_0808, 4'b0010);
        wr(LAC_ADDR_ROUTE_HI, 32'h0000_0B13);
        req(32'h0808_0000, 4'b0100);
        ce <= 1'b0;
        req(32'h0000_0000, 4'b0100);
        ce <= 1'b1;
        req(32'h0000_0000, 4'b0000);
        wr(LAC_ADDR_ROUTE_LO, 32'h0000_0B05);
        req(32'h0000_0820, 4'b0000);
        wr(LAC_ADDR_ROUTE_HI, 32'h0000_FFFF);
        rdc("route read", LAC_ADDR_ROUTE_HI, 32'h0000_1F1F);
    endtask
    task automatic t_conv;
        wr(LAC_ADDR_CONV, 32'h0000_0017);
        elem_out <= 32'h0080_0000;
        tick(4);
        chk("trigger off", 32'h0, {31'h0, convst_trig});
        wr(LAC_ADDR_CONV, 32'h0000_FFF7);
        tick(4);
        chk("trigger on", 32'h1, {31'h0, convst_trig});
        rdc("conv read", LAC_ADDR_CONV, 32'h0000_0037);
        elem_out <= 32'h0040_0000;
        tick(4);
        chk("trigger other", 32'h0, {31'h0, convst_trig});
    endtask
    task automatic t_io;
        wr(LAC_ADDR_SWIN, 32'h0000_A5C3);
        tick(1);
        chk("input bits", 32'h0000_A5C3, {16'h0, sw_din});
        elem_out <= 32'h1234_8765;
        tick(3);
        rdc("outputs low", LAC_ADDR_OUT_LO, 32'h0000_8765);
        rdc("outputs high", LAC_ADDR_OUT_HI, 32'h0000_1234);
        wr(LAC_ADDR_OUT_LO, 32'h0000_FFFF);
        rdc("outputs ro", LAC_ADDR_OUT_LO, 32'h0000_8765);
    endtask
    task automatic t_int;
        elem_out <= 32'h0000_0000;
        wr(LAC_ADDR_ROUTE_LO, 32'h0000_0010);
        wr(LAC_ADDR_ROUTE_HI, 32'h0000_0000);
        wr(LAC_ADDR_CONV, 32'h0000_0000);
        wr(LAC_ADDR_EVT_STATUS, 32'h0000_001F);
        rdc("status clear", LAC_ADDR_EVT_STATUS, 32'h0);
        elem_out <= 32'h0000_0001;
        tick(4);
        rdc("status set", LAC_ADDR_EVT_STATUS, 32'h1);
        chk("int masked", 32'h0, {31'h0, int_out});
        wr(LAC_ADDR_EVT_MASK, 32'h0000_0001);
        tick(2);
        chk("int raised", 32'h1, {31'h0, int_out});
        wr(LAC_ADDR_EVT_STATUS, 32'h0000_0001);
        tick(2);
        chk("int cleared", 32'h0, {31'h0, int_out});
        rdc("status after", LAC_ADDR_EVT_STATUS, 32'h0);
    endtask
    task automatic t_lock;
        wr(LAC_ADDR_LOCK, 32'h0000_0000);
        tick(1);
        chk("lock zero", 32'h0, {31'h0, write_locked});
        wr(LAC_ADDR_SWIN, 32'h0000_1111);
        wr(LAC_ADDR_LOCK, 32'h0000_FFFF);
        tick(1);
        chk("lock set", 32'h1, {31'h0, write_locked});
        wr(LAC_ADDR_SWIN, 32'h0000_2222);
        wr(LAC_ADDR_CLK_SEL, 32'h0000_7777);
        tick(1);
        chk("locked bits", 32'h0000_1111, {16'h0, sw_din});
        rdc("locked clock", LAC_ADDR_CLK_SEL, 32'h0000_4321);
        rdc("lock read", LAC_ADDR_LOCK, 32'h0000_0001);
        wr(LAC_ADDR_LOCK, 32'h0000_0000);
        tick(1);
        chk("lock stays", 32'h1, {31'h0, write_locked});
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        tick(1);
        chk("lock reset", 32'h0, {15'h0, sw_din, write_locked});
        wr(LAC_ADDR_SWIN, 32'h0000_3333);
        tick(1);
        chk("unlocked bits", 32'h0000_3333, {16'h0, sw_din});
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
    initial begin
        {nrst, hsel, hwrite, htrans, haddr, hwdata, elem_out} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        fail_count = 0;
        total_checks = 0;
        tick(2);
        nrst <= 1'b1;
        hsel <= 1'b1;
        t_reset();
        t_clk();
        t_route();
        t_conv();
        t_io();
        t_int();
        t_lock();
        close_out();
    end
endmodule
